// ---- vtm_defs.vh ----
/*
 * Constants for the video timing measurement block: register offsets,
 * field positions, reset values and measurement counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef VTM_DEFS_VH
`define VTM_DEFS_VH

// Register offsets on the two-wire bus
`define VTM_ADR_SRT_CTRL 16'h843F
`define VTM_ADR_AUTO_SIZE 16'h858B
`define VTM_ADR_HFP_LO 16'h8580
`define VTM_ADR_HFP_HI 16'h8581
`define VTM_ADR_HSYNC_LO 16'h8582
`define VTM_ADR_HSYNC_HI 16'h8583
`define VTM_ADR_HBP_LO 16'h8584
`define VTM_ADR_HBP_HI 16'h8585
`define VTM_ADR_VFP_LO 16'h8586
`define VTM_ADR_VFP_HI 16'h8587
`define VTM_ADR_VSYNC 16'h8588
`define VTM_ADR_VBP_LO 16'h8589
`define VTM_ADR_VBP_HI 16'h858A

// Field positions
`define VTM_BIT_SOFT_RESET 0
`define VTM_BIT_AUTOINC_DIS 6
`define VTM_BIT_AUTO_SIZE 0

// Reset values
`define VTM_RST_BYTE 8'h00
`define VTM_RST_COUNT 11'h000
`define VTM_MIN_INIT 11'h7FF

// Bus slave address, arbitrary value
`define VTM_DEV_ADDR 7'h2C

// Fields observed per measurement
`define VTM_MEAS_FIELDS 2'h2

`endif

// ---- vtm_sync3.v ----
/*
 * Three-stage input synchroniser for a bundle of asynchronous pins.
 * Assumes each bit is an independent level from outside the clock domain.
 */
`timescale 1ns/1ps
`include "vtm_defs.vh"

module vtm_sync3 #(
	parameter W = 6
) (
	input wire clock_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;
reg [W-1:0] level;

assign q_o = level;

////////////////////////////////////////////////////////////////////////////////
genvar gi;
generate
	for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
		// Level moves only once stages two and three agree, filtering one-cycle glitches
		always @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				stage1[gi] <= 1'b0;
				stage2[gi] <= 1'b0;
				stage3[gi] <= 1'b0;
				level[gi] <= 1'b0;
			end else begin
				stage1[gi] <= d_i[gi];
				stage2[gi] <= stage1[gi];
				stage3[gi] <= stage2[gi];
				if (stage2[gi] == stage3[gi]) begin
					level[gi] <= stage3[gi];
				end
			end
		end
	end
endgenerate

endmodule

// ---- vtm_top.v ----
/*
 * Video timing measurement with two-wire register access.
 * Measures horizontal porches and sync in pixels and vertical porches and
 * sync in lines, and holds the soft reset and test control register.
 * Assumes the pixel clock, syncs and video-present level are asynchronous
 * pins, active high, and that sda is open drain with an external pull-up.
 */
`timescale 1ns/1ps
`include "vtm_defs.vh"

module vtm_top #(
	parameter [6:0] DEV_ADDR = `VTM_DEV_ADDR
) (
	input wire clock_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	input wire pix_clk_i,
	input wire hsync_i,
	input wire vsync_i,
	input wire video_i,
	output reg meas_busy_o
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RX = 3'h1;
localparam [2:0] ST_ACK = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_RACK = 3'h4;

localparam [1:0] M_IDLE = 2'h0;
localparam [1:0] M_ARM = 2'h1;
localparam [1:0] M_RUN = 2'h2;

// Saturating 11-bit increment, so a missing sync never wraps to a small minimum
function [10:0] inc11;
	input [10:0] x;
	begin
		inc11 = (x == 11'h7FF) ? x : x + 11'h001;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
wire [5:0] sq;
reg scl_d;
reg sda_d;
reg pclk_d;

vtm_sync3 #(
	.W(6)
) u_sync (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.d_i({video_i, vsync_i, hsync_i, pix_clk_i, sda_i, scl_i}),
	.q_o(sq)
);

wire scl = sq[0];
wire sda = sq[1];
wire hs = sq[3];
wire vs = sq[4];
wire vid = sq[5];
wire scl_rise = scl & ~scl_d;
wire scl_fall = ~scl & scl_d;
wire bus_start = scl & scl_d & sda_d & ~sda;
wire bus_stop = scl & scl_d & ~sda_d & sda;
wire pix_rise = sq[2] & ~pclk_d;

// Previous filtered levels; reset matches the synchroniser so reset leaves no false edge
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		scl_d <= 1'b0;
		sda_d <= 1'b0;
		pclk_d <= 1'b0;
	end else begin
		scl_d <= scl;
		sda_d <= sda;
		pclk_d <= sq[2];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Two-wire slave
reg [2:0] i2c_st;
reg [3:0] bitcnt;
reg [7:0] sh;
reg [1:0] byte_idx;
reg rw;
reg nack;
reg [15:0] ptr;
reg wr_stb;
reg [15:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] rd_data;
reg autoinc_disable;
reg soft_reset_bit;

wire [15:0] ptr_next = autoinc_disable ? ptr : ptr + 16'h0001;

// The slave is outside soft reset so a running transfer completes
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		i2c_st <= ST_IDLE;
		bitcnt <= 4'h0;
		sh <= 8'h00;
		byte_idx <= 2'h0;
		rw <= 1'b0;
		nack <= 1'b0;
		ptr <= 16'h0000;
		wr_stb <= 1'b0;
		wr_addr <= 16'h0000;
		wr_data <= 8'h00;
		sda_o <= 1'b0;
		sda_oe_o <= 1'b0;
	end else begin
		wr_stb <= 1'b0;
		sda_o <= 1'b0;
		if (bus_start) begin
			i2c_st <= ST_RX;
			bitcnt <= 4'h0;
			byte_idx <= 2'h0;
			sda_oe_o <= 1'b0;
		end else if (bus_stop) begin
			i2c_st <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			case (i2c_st)
			ST_RX: begin
				if (scl_rise) begin
					sh <= {sh[6:0], sda};
					bitcnt <= bitcnt + 4'h1;
				end else if (scl_fall && bitcnt == 4'h8) begin
					bitcnt <= 4'h0;
					i2c_st <= ST_ACK;
					sda_oe_o <= 1'b1;
					if (byte_idx == 2'h0) begin
						if (sh[7:1] == DEV_ADDR) begin
							rw <= sh[0];
							byte_idx <= 2'h1;
						end else begin
							i2c_st <= ST_IDLE;
							sda_oe_o <= 1'b0;
						end
					end else if (byte_idx == 2'h1) begin
						ptr[15:8] <= sh;
						byte_idx <= 2'h2;
					end else if (byte_idx == 2'h2) begin
						ptr[7:0] <= sh;
						byte_idx <= 2'h3;
					end else begin
						wr_stb <= 1'b1;
						wr_addr <= ptr;
						wr_data <= sh;
						ptr <= ptr_next;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					if (rw) begin
						i2c_st <= ST_TX;
						sh <= rd_data;
						sda_oe_o <= ~rd_data[7];
						ptr <= ptr_next;
					end else begin
						i2c_st <= ST_RX;
						sda_oe_o <= 1'b0;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (bitcnt == 4'h7) begin
						bitcnt <= 4'h0;
						sda_oe_o <= 1'b0;
						i2c_st <= ST_RACK;
					end else begin
						bitcnt <= bitcnt + 4'h1;
						sh <= {sh[6:0], 1'b0};
						sda_oe_o <= ~sh[6];
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					nack <= sda;
				end else if (scl_fall) begin
					if (nack) begin
						i2c_st <= ST_IDLE;
					end else begin
						i2c_st <= ST_TX;
						sh <= rd_data;
						sda_oe_o <= ~rd_data[7];
						ptr <= ptr_next;
					end
				end
			end
			default: begin
				sda_oe_o <= 1'b0;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Soft reset and test control; this register survives its own reset
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		autoinc_disable <= 1'b0;
		soft_reset_bit <= 1'b0;
	end else begin
		soft_reset_bit <= 1'b0;
		if (wr_stb && wr_addr == `VTM_ADR_SRT_CTRL) begin
			autoinc_disable <= wr_data[`VTM_BIT_AUTOINC_DIS];
			soft_reset_bit <= wr_data[`VTM_BIT_SOFT_RESET];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Measurement state
reg [1:0] meas_st;
reg [1:0] field_n;
reg hs_p;
reg vs_p;
reg line_vid;
reg field_vid;
reg any_vid;
reg bp_run;
reg vbp_run;
reg [10:0] pix_cnt;
reg [10:0] sync_cnt;
reg [10:0] sync_len;
reg [10:0] fp_cnt;
reg [10:0] bp_cnt;
reg [10:0] line_tot;
reg [10:0] vline;
reg [10:0] vtot;
reg [7:0] vs_cnt;
reg [7:0] vsync_len;
reg [10:0] vfp_cnt;
reg [10:0] vbp_cnt;
reg [10:0] min_hfp;
reg [10:0] min_hbp;
reg [10:0] min_vfp;
reg [10:0] min_vbp;
reg [10:0] hfp_r;
reg [9:0] hsync_r;
reg [10:0] hbp_r;
reg [10:0] vfp_r;
reg [7:0] vsync_r;
reg [10:0] vbp_r;

wire run = (meas_st == M_RUN);
wire [10:0] vtot_less_sync = vtot - {3'h0, vsync_len};
wire [9:0] sync_cap = (sync_len[10]) ? 10'h3FF : sync_len[9:0];

// Counters run on sampled pixel edges; minima move only while running.
// Soft reset clears all of it but leaves the bus slave alone.
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		meas_st <= M_IDLE;
		meas_busy_o <= 1'b0;
		field_n <= 2'h0;
		{hs_p, vs_p, line_vid, field_vid, any_vid, bp_run, vbp_run} <= 7'h00;
		{pix_cnt, sync_cnt, sync_len, fp_cnt, bp_cnt, line_tot} <= 66'h0;
		{vline, vtot, vfp_cnt, vbp_cnt} <= 44'h0;
		vs_cnt <= 8'h00;
		vsync_len <= 8'h00;
		{min_hfp, min_hbp, min_vfp, min_vbp} <= {4{`VTM_MIN_INIT}};
		{hfp_r, hbp_r, vfp_r, vbp_r} <= {4{`VTM_RST_COUNT}};
		hsync_r <= 10'h000;
		vsync_r <= `VTM_RST_BYTE;
	end else if (soft_reset_bit) begin
		meas_st <= M_IDLE;
		meas_busy_o <= 1'b0;
		field_n <= 2'h0;
		{hs_p, vs_p, line_vid, field_vid, any_vid, bp_run, vbp_run} <= 7'h00;
		{pix_cnt, sync_cnt, sync_len, fp_cnt, bp_cnt, line_tot} <= 66'h0;
		{vline, vtot, vfp_cnt, vbp_cnt} <= 44'h0;
		vs_cnt <= 8'h00;
		vsync_len <= 8'h00;
		{min_hfp, min_hbp, min_vfp, min_vbp} <= {4{`VTM_MIN_INIT}};
		{hfp_r, hbp_r, vfp_r, vbp_r} <= {4{`VTM_RST_COUNT}};
		hsync_r <= 10'h000;
		vsync_r <= `VTM_RST_BYTE;
	end else begin
		if (pix_rise) begin
			hs_p <= hs;
			vs_p <= vs;
			pix_cnt <= inc11(pix_cnt);
			// Line start: close out the line just ended
			if (hs && !hs_p) begin
				pix_cnt <= 11'h001;
				sync_cnt <= 11'h001;
				line_tot <= pix_cnt;
				line_vid <= 1'b0;
				bp_run <= 1'b0;
				if (run && line_vid && fp_cnt < min_hfp) begin
					min_hfp <= fp_cnt;
				end
				vline <= inc11(vline);
				if (vs) begin
					vs_cnt <= (vs_cnt == 8'hFF) ? vs_cnt : vs_cnt + 8'h01;
				end else if (line_vid) begin
					vfp_cnt <= 11'h000;
					field_vid <= 1'b1;
					if (vbp_run) begin
						vbp_run <= 1'b0;
						if (run && vbp_cnt < min_vbp) begin
							min_vbp <= vbp_cnt;
						end
					end
				end else begin
					vfp_cnt <= inc11(vfp_cnt);
					if (vbp_run) begin
						vbp_cnt <= inc11(vbp_cnt);
					end
				end
			end else if (hs) begin
				sync_cnt <= inc11(sync_cnt);
			end
			// Sync end starts the back porch run
			if (!hs && hs_p) begin
				sync_len <= sync_cnt;
				bp_cnt <= 11'h000;
				bp_run <= 1'b1;
				fp_cnt <= 11'h000;
			end else if (!hs) begin
				if (vid) begin
					fp_cnt <= 11'h000;
					line_vid <= 1'b1;
					if (run) begin
						any_vid <= 1'b1;
					end
					if (bp_run) begin
						bp_run <= 1'b0;
						if (run && bp_cnt < min_hbp) begin
							min_hbp <= bp_cnt;
						end
					end
				end else begin
					fp_cnt <= inc11(fp_cnt);
					if (bp_run) begin
						bp_cnt <= inc11(bp_cnt);
					end
				end
			end
			// Vertical sync end starts the vertical back porch run
			if (!vs && vs_p) begin
				vsync_len <= vs_cnt;
				vs_cnt <= 8'h00;
				vbp_cnt <= 11'h000;
				vbp_run <= 1'b1;
			end
			// Vertical sync start closes the field
			if (vs && !vs_p) begin
				if (run && field_vid && vfp_cnt < min_vfp) begin
					min_vfp <= vfp_cnt;
				end
				vtot <= vline;
				vline <= 11'h000;
				field_vid <= 1'b0;
				if (run) begin
					field_n <= field_n + 2'h1;
				end
			end
		end

		// Measurement sequencing
		case (meas_st)
		M_ARM: begin
			if (pix_rise && vs && !vs_p) begin
				meas_st <= M_RUN;
				field_n <= 2'h0;
			end
		end
		M_RUN: begin
			if (field_n == `VTM_MEAS_FIELDS) begin
				meas_st <= M_IDLE;
				meas_busy_o <= 1'b0;
				hfp_r <= any_vid ? min_hfp : `VTM_RST_COUNT;
				hsync_r <= any_vid ? sync_cap : 10'h000;
				hbp_r <= any_vid ? min_hbp : line_tot;
				vfp_r <= any_vid ? min_vfp : `VTM_RST_COUNT;
				vsync_r <= vsync_len;
				vbp_r <= any_vid ? min_vbp : vtot_less_sync;
			end
		end
		default: begin
			meas_st <= M_IDLE;
		end
		endcase

		// Host write comes last so a new start wins over completion
		if (wr_stb && wr_addr == `VTM_ADR_AUTO_SIZE) begin
			if (wr_data[`VTM_BIT_AUTO_SIZE]) begin
				meas_st <= M_ARM;
				meas_busy_o <= 1'b1;
				any_vid <= 1'b0;
				{min_hfp, min_hbp, min_vfp, min_vbp} <= {4{`VTM_MIN_INIT}};
				{hfp_r, hbp_r, vfp_r, vbp_r} <= {4{`VTM_RST_COUNT}};
				hsync_r <= 10'h000;
				vsync_r <= `VTM_RST_BYTE;
			end else begin
				meas_st <= M_IDLE;
				meas_busy_o <= 1'b0;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read data; unmapped addresses read zero, results ignore writes
always @* begin
	if (ptr == `VTM_ADR_SRT_CTRL) begin
		rd_data = {1'b0, autoinc_disable, 5'h00, soft_reset_bit};
	end else if (ptr == `VTM_ADR_AUTO_SIZE) begin
		rd_data = {7'h00, meas_busy_o};
	end else if (ptr == `VTM_ADR_HFP_LO) begin
		rd_data = hfp_r[7:0];
	end else if (ptr == `VTM_ADR_HFP_HI) begin
		rd_data = {5'h00, hfp_r[10:8]};
	end else if (ptr == `VTM_ADR_HSYNC_LO) begin
		rd_data = hsync_r[7:0];
	end else if (ptr == `VTM_ADR_HSYNC_HI) begin
		rd_data = {6'h00, hsync_r[9:8]};
	end else if (ptr == `VTM_ADR_HBP_LO) begin
		rd_data = hbp_r[7:0];
	end else if (ptr == `VTM_ADR_HBP_HI) begin
		rd_data = {5'h00, hbp_r[10:8]};
	end else if (ptr == `VTM_ADR_VFP_LO) begin
		rd_data = vfp_r[7:0];
	end else if (ptr == `VTM_ADR_VFP_HI) begin
		rd_data = {5'h00, vfp_r[10:8]};
	end else if (ptr == `VTM_ADR_VSYNC) begin
		rd_data = vsync_r;
	end else if (ptr == `VTM_ADR_VBP_LO) begin
		rd_data = vbp_r[7:0];
	end else if (ptr == `VTM_ADR_VBP_HI) begin
		rd_data = {5'h00, vbp_r[10:8]};
	end else begin
		rd_data = 8'h00;
	end
end

endmodule

// ---- vtm_monitor.sv ----
/*
 * Checker for the video timing measurement top: bus drive and busy flag.
 * Assumes one 10 MHz clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module vtm_monitor (
	input wire clock_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_o,
	input wire pix_clk_i,
	input wire hsync_i,
	input wire vsync_i,
	input wire video_i,
	input wire meas_busy_o
);
	logic vs_q;
	logic [1:0] vs_cnt;

	default clocking mon_cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Counts vsync pin rises while busy; the third one ends a run
	// Pin edges lead the synchronised ones, so the count is ahead of the design
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			vs_q <= 1'b0;
			vs_cnt <= 2'h0;
		end else begin
			vs_q <= vsync_i;
			if (!meas_busy_o)
				vs_cnt <= 2'h0;
			else if (vsync_i && !vs_q && vs_cnt != 2'h3)
				vs_cnt <= vs_cnt + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	reset_idle_a: assert property ($fell(rst_i) |-> !sda_oe_o && !meas_busy_o)
		else $error("bus drive or busy flag set after reset");
	sda_zero_a: assert property (sda_o == 1'b0)
		else $error("open drain data value not low");
	oe_rise_low_a: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("data drive started while clock high");
	oe_stable_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("data drive changed while clock high");
	busy_rise_ack_a: assert property ($rose(meas_busy_o) |-> sda_oe_o)
		else $error("busy rose outside a write acknowledge");
	busy_hold_a: assert property ($rose(meas_busy_o) |=> meas_busy_o [*8])
		else $error("busy dropped right after arming");
	busy_early_a: assert property ($fell(meas_busy_o) |-> sda_oe_o || vs_cnt == 2'h3)
		else $error("busy cleared before the run ended");
	busy_done_a: assert property ($rose(vs_cnt == 2'h3) |-> ##[1:24] !meas_busy_o)
		else $error("busy not cleared after the last field");

	// Main scenarios
	arm_c: cover property ($rose(meas_busy_o));
	done_c: cover property ($fell(meas_busy_o) && vs_cnt == 2'h3);
	ack_c: cover property ($rose(sda_oe_o));
endmodule

bind vtm_top vtm_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .pix_clk_i(pix_clk_i), .hsync_i(hsync_i),
	.vsync_i(vsync_i), .video_i(video_i), .meas_busy_o(meas_busy_o));

// ---- vtm_host.sv ----
/*
 * Microcontroller model: two-wire master with 16-bit register pointer.
 * Assumes an open-drain data wire built outside, with pull-up.
 */
`timescale 1ns/1ps
`include "vtm_defs.vh"

module vtm_host #(
	parameter logic [6:0] DEV = `VTM_DEV_ADDR
) (
	input wire clock_i,
	input wire sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every change lands on a falling clock edge
	task automatic step(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	// Tail of low clock gives the slave's filtered clock time to fall first
	task automatic bitx(input logic b, output logic r);
		sda_oe_o = ~b;
		step(6);
		scl_o = 1'b1;
		step(6);
		r = sda_i;
		scl_o = 1'b0;
		step(4);
	endtask

	task automatic start();
		sda_oe_o = 1'b0;
		step(4);
		scl_o = 1'b1;
		step(6);
		sda_oe_o = 1'b1;
		step(6);
		scl_o = 1'b0;
		step(4);
	endtask

	task automatic stop();
		sda_oe_o = 1'b1;
		step(4);
		scl_o = 1'b1;
		step(6);
		sda_oe_o = 1'b0;
		step(6);
	endtask

	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(a, r);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Device address and register pointer; nak gathers any missing ack
	task automatic addr(input logic [15:0] a, output logic nak);
		logic [7:0] q;
		logic r0, r1, r2;
		start();
		xfer({DEV, 1'b0}, 1'b1, q, r0);
		xfer(a[15:8], 1'b1, q, r1);
		xfer(a[7:0], 1'b1, q, r2);
		nak = r0 | r1 | r2;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic r;
		addr(a, nak);
		xfer(d, 1'b1, q, r);
		stop();
		nak = nak | r;
	endtask

	// Two bytes from a, low byte first; the second is not acknowledged
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		logic nak, r;
		addr(a, nak);
		start();
		xfer({DEV, 1'b1}, 1'b1, v[7:0], r);
		xfer(8'hFF, 1'b0, v[7:0], r);
		xfer(8'hFF, 1'b1, v[15:8], r);
		stop();
	endtask
endmodule

// ---- testbench.sv ----
/*
 * Self-checking bench for the video timing measurement top.
 * Assumes the host model drives the bus and a local raster feeds the video pins.
 */
`timescale 1ns/1ps
`include "vtm_defs.vh"

module testbench;
	localparam int HS = 4, HB = 3, HA = 6, HT = 17;
	localparam int VS = 2, VB = 3, VA = 4, VF = 2, VT = 11;
	logic clock_i, rst_i, pix_clk, hsync, vsync, video, vid_on;
	logic sda_o, sda_oe_o, meas_busy_o, scl, host_oe, nak;
	wire sda_w;
	logic [15:0] v, w;
	int px, ln, failures, checked;

	// Open-drain data line with pull-up
	assign sda_w = ~(host_oe | sda_oe_o);

	vtm_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .pix_clk_i(pix_clk), .hsync_i(hsync), .vsync_i(vsync),
		.video_i(video), .meas_busy_o(meas_busy_o));
	vtm_host u_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe));

	initial clock_i = 1'b0;
	always #50 clock_i = ~clock_i;

	// Pixel clock of 800 ns, toggled on falling system clock edges like every other input
	int pdiv;
	initial pix_clk = 1'b0;
	always @(negedge clock_i) begin
		pdiv = (pdiv == 3) ? 0 : pdiv + 1;
		if (pdiv == 0)
			pix_clk = ~pix_clk;
	end

	// Raster; the first video line is wider so the front porch minimum is one
	always @(negedge pix_clk) begin
		px = (px == HT - 1) ? 0 : px + 1;
		if (px == 0)
			ln = (ln == VT - 1) ? 0 : ln + 1;
		hsync = px < HS;
		vsync = ln < VS;
		video = vid_on && ln >= VS + VB && ln < VS + VB + VA && px >= HS + HB &&
			px < HS + HB + HA + ((ln == VS + VB) ? 3 : 0);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] seen, exp, input logic tol);
		checked++;
		if (!(seen === exp || (tol && (seen === exp + 16'h1 || seen + 16'h1 === exp)))) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd_chk(input string name, input logic [15:0] a, exp, input logic tol);
		u_host.rd(a, v);
		chk(name, v, exp, tol);
	endtask

	// Bounded wait; the limit covers three fields
	task automatic wait_idle();
		for (int i = 0; i < 6000 && meas_busy_o !== 1'b0; i++)
			@(negedge clock_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		logic [15:0] adr [6] = '{`VTM_ADR_HFP_LO, `VTM_ADR_HSYNC_LO, `VTM_ADR_HBP_LO,
			`VTM_ADR_VFP_LO, `VTM_ADR_VSYNC, `VTM_ADR_VBP_LO};
		foreach (adr[i])
			rd_chk("result", adr[i], 16'h0000, 1'b0);
		rd_chk("ctrl", `VTM_ADR_SRT_CTRL, 16'h0000, 1'b0);
		u_host.wr(`VTM_ADR_HBP_LO, 8'h5A, nak);
		rd_chk("hbp_wr", `VTM_ADR_HBP_LO, 16'h0000, 1'b0);
	endtask

	task automatic t_measure();
		u_host.wr(`VTM_ADR_AUTO_SIZE, 8'h01, nak);
		chk("busy_set", 16'(meas_busy_o), 16'h0001, 1'b0);
		wait_idle();
		chk("busy_clr", 16'(meas_busy_o), 16'h0000, 1'b0);
		rd_chk("hfp", `VTM_ADR_HFP_LO, 16'h0001, 1'b1);
		rd_chk("hsync", `VTM_ADR_HSYNC_LO, 16'(HS), 1'b1);
		rd_chk("hbp", `VTM_ADR_HBP_LO, 16'(HB), 1'b1);
		rd_chk("vfp", `VTM_ADR_VFP_LO, 16'(VF), 1'b1);
		u_host.rd(`VTM_ADR_VSYNC, v);
		chk("vsync", {8'h00, v[7:0]}, 16'(VS), 1'b1);
		rd_chk("vbp", `VTM_ADR_VBP_LO, 16'(VB), 1'b1);
	endtask

	// Re-arming clears old results; a zero write then aborts the run
	task automatic t_rearm();
		u_host.wr(`VTM_ADR_AUTO_SIZE, 8'h01, nak);
		u_host.wr(`VTM_ADR_AUTO_SIZE, 8'h00, nak);
		chk("busy_abort", 16'(meas_busy_o), 16'h0000, 1'b0);
		rd_chk("hsync_clr", `VTM_ADR_HSYNC_LO, 16'h0000, 1'b0);
	endtask

	task automatic t_novideo();
		vid_on = 1'b0;
		u_host.wr(`VTM_ADR_AUTO_SIZE, 8'h01, nak);
		wait_idle();
		rd_chk("hfp_nv", `VTM_ADR_HFP_LO, 16'h0000, 1'b0);
		rd_chk("vfp_nv", `VTM_ADR_VFP_LO, 16'h0000, 1'b0);
		u_host.rd(`VTM_ADR_HSYNC_LO, v);
		chk("hsync_nv", v, 16'h0000, 1'b0);
		u_host.rd(`VTM_ADR_HBP_LO, w);
		chk("h_sum", v + w, 16'(HT), 1'b1);
		u_host.rd(`VTM_ADR_VSYNC, v);
		u_host.rd(`VTM_ADR_VBP_LO, w);
		chk("v_sum", {8'h00, v[7:0]} + w, 16'(VT), 1'b1);
		vid_on = 1'b1;
	endtask

	// Without auto-increment both read bytes come from the control register
	task automatic t_autoinc();
		u_host.wr(`VTM_ADR_SRT_CTRL, 8'h40, nak);
		rd_chk("ctrl_aid", `VTM_ADR_SRT_CTRL, 16'h4040, 1'b0);
	endtask

	// Soft reset while idle with stored results, then in the middle of a run
	task automatic t_softreset();
		u_host.wr(`VTM_ADR_SRT_CTRL, 8'h41, nak);
		chk("soft_reset_bit_ack", 16'(nak), 16'h0000, 1'b0);
		rd_chk("ctrl_soft_reset_bit", `VTM_ADR_SRT_CTRL, 16'h4040, 1'b0);
		rd_chk("hbp_soft_reset_bit", `VTM_ADR_HBP_LO, 16'h0000, 1'b0);
		u_host.wr(`VTM_ADR_AUTO_SIZE, 8'h01, nak);
		u_host.wr(`VTM_ADR_SRT_CTRL, 8'h01, nak);
		chk("soft_reset_bit_ack2", 16'(nak), 16'h0000, 1'b0);
		chk("busy_soft_reset_bit", 16'(meas_busy_o), 16'h0000, 1'b0);
		rd_chk("ctrl_end", `VTM_ADR_SRT_CTRL, 16'h0000, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence; four clocks after reset let the pin synchronisers settle
	initial begin
		rst_i = 1'b1;
		vid_on = 1'b1;
		hsync = 1'b0;
		vsync = 1'b0;
		video = 1'b0;
		failures = 0;
		checked = 0;
		repeat (20) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clock_i);
		t_defaults();
		t_measure();
		t_rearm();
		t_novideo();
		t_autoinc();
		t_softreset();
		end_sim();
	end

	// Watchdog at about three times the expected run length
	initial begin
		#10_000_000;
		failures++;
		end_sim();
	end
endmodule
